// ### src/omd_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "omd_params.svh"
module omd_decoder #(
    parameter int ENTRIES  = `OMD_MAP_ENTRIES,   // Map entries
    parameter int IDX_BITS = 13                  // Entry index width
) (
    input  wire logic                 mclk,           // Clock, 10 MHz
    input  wire logic                 rst_b,          // Sync reset, active low
    // Map maintenance port
    input  wire logic                 map_wr,         // Write one map entry, pulse
    input  wire logic [31:0]          map_addr,       // Address inside the segment
    input  wire logic [1:0]           map_attr,       // Attribute to store
    input  wire logic                 clear_map_command, // Clear whole map, pulse
    input  wire logic                 emu_paused,     // Emulation paused level
    output logic                      map_seg_err,    // Window change refused, pulse
    output logic                      clear_refused,  // Clear refused in run, pulse
    // Configuration
    input  wire omd_pkg::omd_en_mode_t shadow_region_enable, // Space selection
    input  wire logic [2:0]           single_region_select, // Space for single mode
    input  wire logic                 wide_cpu,       // 32-bit address processor
    input  wire logic                 wait_wr,        // Load wait setting, pulse
    input  wire logic [2:0]           wait_val,       // Proposed wait setting
    output logic [2:0]                shadow_wait_setting, // Current wait setting
    output logic                      wait_illegal,   // Illegal value, pulse
    input  wire logic                 clk_is_8mhz,    // Target clock 8 MHz strap
    input  wire logic                 clk_above_8mhz, // Target clock faster than 8 MHz
    // Processor bus
    input  wire logic                 as_b,           // Address strobe, active low, pin
    input  wire logic                 rw,             // 1 read, 0 write
    input  wire logic [2:0]           fc,             // Status space code
    input  wire logic [31:0]          addr,           // Bus address
    input  wire logic                 shadow_ready_signal, // Overlay ready, pin
    output logic                      ovl_sel,        // Cycle goes to overlay
    output logic                      ovl_we,         // Overlay write enable
    output logic [23:0]               ovl_addr,       // Internal overlay address
    output logic                      dsack_b,        // Acknowledge, active low
    output logic                      port16,         // Answers as 16-bit port
    output logic                      tgt_wait,       // Target access one wait
    output logic                      write_viol,     // Write violation, pulse
    output logic                      access_viol     // Access violation, pulse
);
    initial begin
        if (ENTRIES != (1 << IDX_BITS) || IDX_BITS + `OMD_SEG_BITS != `OMD_INT_ABITS) begin
            $error("omd_decoder: entries must span the 24-bit space");
        end
    end

    logic [1:0]       map_q [ENTRIES];  // Attribute per 2K segment
    logic [7:0]       seg_q;            // Held top address byte
    logic             seg_valid_q;      // Some non-target segment exists
    logic             as_s;             // Synchronised strobe
    logic             rdy_s;            // Synchronised ready
    logic             as_d1_q;          // Strobe last cycle
    omd_pkg::omd_state_t st_q;          // Cycle state
    logic [2:0]       wcnt_q;           // Wait counter
    logic [IDX_BITS-1:0] map_idx;       // Maintenance index
    logic [IDX_BITS-1:0] bus_idx;       // Bus index
    logic             seg_ok;           // Request within window
    logic [1:0]       cur_attr;         // Attribute of bus address
    logic             seg_match;        // Bus top byte matches window
    logic             space_en;         // Status space enabled
    logic             hit;              // Overlay mapped and enabled
    logic             start;            // Strobe falling edge

    omd_sync u_as (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (~as_b),
        .q     (as_s)
    );
    omd_sync u_rdy (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (shadow_ready_signal),
        .q     (rdy_s)
    );

    // Index within the 24-bit space; top byte held separately
    assign map_idx = map_addr[`OMD_INT_ABITS-1:`OMD_SEG_BITS];
    assign bus_idx = addr[`OMD_INT_ABITS-1:`OMD_SEG_BITS];
    // Window check only matters for non-target attributes on wide cpu
    assign seg_ok  = !wide_cpu || !seg_valid_q || map_attr == `OMD_ATTR_TARGET
                     || map_addr[31:24] == seg_q;

    // Map storage; clear and writes never touch overlay data, only tags
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < ENTRIES; i++) begin
                map_q[i] <= `OMD_ATTR_TARGET;
            end
        end else if (clear_map_command && emu_paused) begin
            // Whole map back to target
            for (int i = 0; i < ENTRIES; i++) begin
                map_q[i] <= `OMD_ATTR_TARGET;
            end
        end else if (map_wr && seg_ok) begin
            map_q[map_idx] <= map_attr;
        end
    end

    // Segment window held once a non-target entry is placed
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            seg_q       <= 8'h00;
            seg_valid_q <= 1'b0;
        end else if (clear_map_command && emu_paused) begin
            seg_valid_q <= 1'b0;
        end else if (map_wr && seg_ok && map_attr != `OMD_ATTR_TARGET) begin
            seg_q       <= map_addr[31:24];
            seg_valid_q <= 1'b1;
        end
    end

    // Maintenance error pulses
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            map_seg_err   <= 1'b0;
            clear_refused <= 1'b0;
        end else begin
            map_seg_err   <= map_wr && !seg_ok && !(clear_map_command && emu_paused);
            clear_refused <= clear_map_command && !emu_paused;
        end
    end

    // Wait setting; the narrow processors may also use zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            shadow_wait_setting <= `OMD_WAIT_DEFAULT;
            wait_illegal        <= 1'b0;
        end else begin
            wait_illegal <= 1'b0;
            if (wait_wr) begin
                if (wide_cpu && wait_val < `OMD_WAIT_MIN) begin
                    wait_illegal <= 1'b1;
                end else begin
                    shadow_wait_setting <= wait_val;
                end
            end
        end
    end

    // Space decode from the enable mode
    always_comb begin
        case (shadow_region_enable)
            omd_pkg::OMD_EN_CODE: space_en = fc == `OMD_FC_SCODE;
            omd_pkg::OMD_EN_DATA: space_en = fc == `OMD_FC_SDATA;
            omd_pkg::OMD_EN_BOTH: space_en = fc == `OMD_FC_SCODE || fc == `OMD_FC_SDATA;
            omd_pkg::OMD_EN_ALL:  space_en = wide_cpu ? 1'b1
                                  : (fc == `OMD_FC_UDATA || fc == `OMD_FC_UP
                                     || fc == `OMD_FC_SDATA || fc == `OMD_FC_SCODE
                                     || fc == `OMD_FC_CPU);
            omd_pkg::OMD_EN_SINGLE: space_en = (single_region_select == 3'h0
                                     || single_region_select == 3'h3
                                     || single_region_select == 3'h4)
                                     && fc == single_region_select;
            default:              space_en = 1'b0;
        endcase
    end

    assign seg_match = !wide_cpu || (seg_valid_q && addr[31:24] == seg_q);
    assign cur_attr  = seg_match ? map_q[bus_idx] : `OMD_ATTR_TARGET;
    assign hit       = cur_attr != `OMD_ATTR_TARGET && space_en;
    assign start     = as_s && !as_d1_q;

    // Strobe history for edge detect
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            as_d1_q <= 1'b0;
        end else begin
            as_d1_q <= as_s;
        end
    end

    // Bus cycle sequencer
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q   <= omd_pkg::OMD_IDLE;
            wcnt_q <= 3'h0;
        end else begin
            case (st_q)
                omd_pkg::OMD_IDLE: begin
                    if (start && hit && cur_attr != `OMD_ATTR_FORBID) begin
                        st_q <= omd_pkg::OMD_WAIT;
                        // 8 MHz needs no extra waits
                        wcnt_q <= clk_is_8mhz ? 3'h0 : shadow_wait_setting - 3'h1;
                    end
                end
                omd_pkg::OMD_WAIT: begin
                    if (rdy_s && wcnt_q == 3'h0) begin
                        st_q <= omd_pkg::OMD_ACK;
                    end else if (wcnt_q != 3'h0) begin
                        wcnt_q <= wcnt_q - 3'h1;
                    end
                end
                omd_pkg::OMD_ACK: begin
                    if (!as_s) begin
                        st_q <= omd_pkg::OMD_IDLE;
                    end
                end
                default: st_q <= omd_pkg::OMD_IDLE;
            endcase
        end
    end

    // Bus outputs registered
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ovl_sel  <= 1'b0;
            ovl_we   <= 1'b0;
            ovl_addr <= 24'h000000;
            dsack_b  <= 1'b1;
            port16   <= 1'b0;
            tgt_wait <= 1'b0;
        end else begin
            ovl_sel  <= as_s && hit && cur_attr != `OMD_ATTR_FORBID;
            // Nonwritable blocks the store strobe
            ovl_we   <= as_s && hit && !rw && cur_attr == `OMD_ATTR_RW;
            ovl_addr <= addr[23:0];
            dsack_b  <= !(st_q == omd_pkg::OMD_ACK && as_s);
            port16   <= wide_cpu;
            // Target access in the overlay segment waits on ready, on a wide cpu with the target clock above 8 MHz
            tgt_wait <= as_s && !hit && wide_cpu && clk_above_8mhz
                        && seg_match && !rdy_s;
        end
    end

    // Violations at cycle start
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            write_viol  <= 1'b0;
            access_viol <= 1'b0;
        end else begin
            write_viol  <= start && hit && !rw && cur_attr == `OMD_ATTR_NOWR;
            access_viol <= start && hit && cur_attr == `OMD_ATTR_FORBID;
        end
    end

    a_ro_no_we: assert property (@(posedge mclk) disable iff (!rst_b)
        write_viol |-> !ovl_we) else $error("write to nonwritable enabled store");
    a_forbid_no_sel: assert property (@(posedge mclk) disable iff (!rst_b)
        access_viol |-> !ovl_sel) else $error("forbidden region selected");
    a_wait_range: assert property (@(posedge mclk) disable iff (!rst_b)
        wide_cpu |-> shadow_wait_setting != 3'h0) else $error("wait below one");
    a_clear_run: assert property (@(posedge mclk) disable iff (!rst_b)
        clear_map_command && !emu_paused |=> clear_refused) else $error("clear not refused");
    a_seg_err: assert property (@(posedge mclk) disable iff (!rst_b)
        map_wr && !seg_ok && !clear_map_command |=> map_seg_err) else $error("no segment error");
    a_illegal: assert property (@(posedge mclk) disable iff (!rst_b)
        wait_wr && wide_cpu && wait_val == 3'h0 |=> wait_illegal && $stable(shadow_wait_setting))
        else $error("zero wait accepted");
    a_ack_needs_rdy: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(st_q == omd_pkg::OMD_ACK) |-> $past(rdy_s)) else $error("ack without ready");
    a_port16: assert property (@(posedge mclk) disable iff (!rst_b)
        wide_cpu ##1 wide_cpu |-> port16) else $error("port width wrong");

    // Cycle start on an enabled, mapped segment that may be served
    sequence s_ovl_start;
        st_q == omd_pkg::OMD_IDLE && start && hit && cur_attr != `OMD_ATTR_FORBID;
    endsequence

    // Cycle start on a forbidden segment
    sequence s_forbid_start;
        st_q == omd_pkg::OMD_IDLE && start && hit && cur_attr == `OMD_ATTR_FORBID;
    endsequence

    // Served cycle must enter the wait state next
    a_ovl_enter: assert property (@(posedge mclk) disable iff (!rst_b)
        s_ovl_start |=> st_q == omd_pkg::OMD_WAIT) else $error("no wait entry");

    // Forbidden cycle flags and never leaves idle
    a_forbid_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        s_forbid_start |=> access_viol && st_q == omd_pkg::OMD_IDLE)
        else $error("forbidden cycle not flagged");

    // 8 MHz target clock strap loads no extra waits
    a_fast_wait: assert property (@(posedge mclk) disable iff (!rst_b)
        s_ovl_start and clk_is_8mhz |=> wcnt_q == 3'h0) else $error("waits at 8 MHz");

    // Store to nonwritable segment flags and keeps storage strobe low
    a_nowr_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        start && hit && !rw && cur_attr == `OMD_ATTR_NOWR |=> write_viol && !ovl_we)
        else $error("nonwritable store not flagged");

    // Acknowledge follows the ack state while the strobe stands
    a_ack_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        st_q == omd_pkg::OMD_ACK && as_s |=> !dsack_b) else $error("ack missing");

    // No acknowledge unless the sequencer was in its ack state
    a_ack_only: assert property (@(posedge mclk) disable iff (!rst_b)
        !dsack_b |-> $past(st_q == omd_pkg::OMD_ACK)) else $error("stray ack");

    // Clear returns tags to target and frees the window
    a_clear_all: assert property (@(posedge mclk) disable iff (!rst_b)
        clear_map_command && emu_paused |=> map_q[0] == `OMD_ATTR_TARGET && !seg_valid_q)
        else $error("clear incomplete");

    // Accepted non-target entry pins the window byte
    a_seg_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        map_wr && seg_ok && map_attr != `OMD_ATTR_TARGET && !clear_map_command
        |=> seg_valid_q && seg_q == $past(map_addr[31:24]))
        else $error("window byte lost");

    // Overlay address is the low 24 bits of the bus address
    a_ovl_addr: assert property (@(posedge mclk) disable iff (!rst_b)
        as_s |=> ovl_addr == $past(addr[23:0])) else $error("overlay address wrong");
endmodule
`default_nettype wire

// ### src/omd_params.svh
`ifndef OMD_PARAMS_SVH
`define OMD_PARAMS_SVH
// Segment granularity: 2K bytes, so 11 offset bits
`define OMD_SEG_BITS      11
// Internal overlay address width
`define OMD_INT_ABITS     24
// Map entries covering the 24-bit internal space
`define OMD_MAP_ENTRIES   8192
// Attribute encodings
`define OMD_ATTR_TARGET   2'h0
`define OMD_ATTR_RW       2'h1
`define OMD_ATTR_NOWR     2'h2
`define OMD_ATTR_FORBID   2'h3
// Status space codes
`define OMD_FC_UDATA      3'h1
`define OMD_FC_UP         3'h2
`define OMD_FC_SDATA      3'h5
`define OMD_FC_SCODE      3'h6
`define OMD_FC_CPU        3'h7
// Wait setting default and limits
`define OMD_WAIT_DEFAULT  3'h1
`define OMD_WAIT_MIN      3'h1
`define OMD_WAIT_MAX      3'h7
`endif

// ### src/omd_pkg.sv
package omd_pkg;
    // Space selection modes of the shadow region enable
    typedef enum logic [2:0] {
        OMD_EN_CODE,
        OMD_EN_DATA,
        OMD_EN_BOTH,
        OMD_EN_ALL,
        OMD_EN_SINGLE
    } omd_en_mode_t;
    // Bus cycle sequencing states
    typedef enum logic [1:0] {
        OMD_IDLE,
        OMD_WAIT,
        OMD_ACK
    } omd_state_t;
endpackage

// ### src/omd_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module omd_sync (
    input  wire logic mclk,    // Clock
    input  wire logic rst_b,   // Sync reset, active low
    input  wire logic d,       // Asynchronous input
    output logic      q        // Filtered level
);
    logic [2:0] sh_q;          // Shift stages

    // Stage chain; stage 0 feeds only stage 1
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sh_q <= 3'h0;
        end else begin
            sh_q <= {sh_q[1:0], d};
        end
    end

    // Accept a change only when the last two stages agree
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            q <= 1'b0;
        end else if (sh_q[1] == sh_q[2]) begin
            q <= sh_q[2];
        end
    end
endmodule
`default_nettype wire

// ### sim/omd_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// Processor bus partner: one strobed cycle per call of run
module omd_cpu_model (
    input  wire logic        mclk,        // Clock
    input  wire logic        dsack_b,     // Acknowledge, active low
    input  wire logic        ovl_sel,     // Overlay selected
    input  wire logic        ovl_we,      // Overlay write enable
    input  wire logic [23:0] ovl_addr,    // Overlay address
    input  wire logic        write_viol,  // Write violation
    input  wire logic        access_viol, // Access violation
    output logic             as_b,        // Address strobe, active low
    output logic             rw,          // 1 read, 0 write
    output logic [2:0]       fc,          // Status space
    output logic [31:0]      addr,        // Bus address
    output logic             shadow_ready_signal // Overlay ready
);
    int low_cnt; // Cycles with strobe low
    initial begin
        as_b = 1'b1;
        rw = 1'b1;
        fc = 3'h0;
        addr = 32'h0;
        low_cnt = 0;
    end
    // Ready lags the strobe by three cycles, like slow memory
    always @(negedge mclk) begin
        low_cnt <= as_b ? 0 : low_cnt + 1;
        shadow_ready_signal <= !as_b && (low_cnt > 2);
    end
    // Flags: sel, we, ack, write viol, access viol
    task automatic run(input logic w, input logic [2:0] f, input logic [31:0] a,
                       output logic [4:0] flg, output logic [23:0] oa, output int n);
        flg = 5'h0;
        oa = 24'h0;
        @(negedge mclk);
        rw = !w;
        fc = f;
        addr = a;
        as_b = 1'b0;
        // Hold until acknowledged or refused, bounded
        for (n = 0; n < 30 && !flg[2] && !flg[0]; n++) begin
            @(posedge mclk);
            #1;
            if (ovl_sel) oa = ovl_addr;
            flg = flg | {ovl_sel, ovl_we, !dsack_b, write_viol, access_viol};
        end
        @(negedge mclk);
        as_b = 1'b1;
        rw = 1'b1;
        fc = ~f;
        addr = ~a; // Released bus never keeps its last value
        // Late pulses, and time for the synchroniser
        repeat (8) begin
            @(posedge mclk);
            #1;
            flg[1:0] = flg[1:0] | {write_viol, access_viol};
        end
    endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module tb_top;
    typedef struct {
        omd_pkg::omd_en_mode_t md; // Space mode
        logic [2:0]  one;          // Single space
        logic        w;            // Write
        logic [2:0]  f;            // Status space
        logic [31:0] a;            // Address
        logic [4:0]  x;            // Expected flags
    } omd_row_t;
    logic mclk, rst_b, map_wr, clear_map_command, emu_paused, map_seg_err, clear_refused;
    logic wide_cpu, wait_wr, wait_illegal, clk_is_8mhz, clk_above_8mhz;
    logic as_b, rw, shadow_ready_signal, ovl_sel, ovl_we, dsack_b, port16, tgt_wait;
    logic write_viol, access_viol, e;
    logic tw_seen, tw_clr;         // Target wait seen, and its clear
    logic [31:0] map_addr, addr;
    logic [1:0]  map_attr;
    logic [2:0]  single_region_select, wait_val, shadow_wait_setting, fc;
    logic [23:0] ovl_addr, oa;
    logic [4:0]  flg;
    omd_pkg::omd_en_mode_t shadow_region_enable;
    int n_mismatch = 0, cmp_count = 0, n1, n2;
    omd_row_t rows [13] = '{
        '{omd_pkg::OMD_EN_CODE, 3'h0, 1'b0, 3'h6, 32'h1f000010, 5'h14},
        '{omd_pkg::OMD_EN_CODE, 3'h0, 1'b0, 3'h5, 32'h1f000010, 5'h00},
        '{omd_pkg::OMD_EN_DATA, 3'h0, 1'b0, 3'h5, 32'h1f000014, 5'h14},
        '{omd_pkg::OMD_EN_DATA, 3'h0, 1'b0, 3'h6, 32'h1f000014, 5'h00},
        '{omd_pkg::OMD_EN_BOTH, 3'h0, 1'b0, 3'h5, 32'h1f000018, 5'h14},
        '{omd_pkg::OMD_EN_BOTH, 3'h0, 1'b1, 3'h6, 32'h1f000020, 5'h1c},
        '{omd_pkg::OMD_EN_ALL, 3'h0, 1'b0, 3'h0, 32'h1f000024, 5'h14},
        '{omd_pkg::OMD_EN_ALL, 3'h0, 1'b0, 3'h3, 32'h1f000028, 5'h14},
        '{omd_pkg::OMD_EN_ALL, 3'h0, 1'b0, 3'h7, 32'h1f00002c, 5'h14},
        '{omd_pkg::OMD_EN_SINGLE, 3'h3, 1'b0, 3'h3, 32'h1f000030, 5'h14},
        '{omd_pkg::OMD_EN_SINGLE, 3'h3, 1'b0, 3'h4, 32'h1f000030, 5'h00},
        '{omd_pkg::OMD_EN_SINGLE, 3'h2, 1'b0, 3'h2, 32'h1f000030, 5'h00},
        '{omd_pkg::OMD_EN_CODE, 3'h0, 1'b0, 3'h6, 32'h1f000810, 5'h00}};
    omd_decoder i_dut (.mclk(mclk), .rst_b(rst_b), .map_wr(map_wr), .map_addr(map_addr),
        .map_attr(map_attr), .clear_map_command(clear_map_command), .emu_paused(emu_paused),
        .map_seg_err(map_seg_err), .clear_refused(clear_refused),
        .shadow_region_enable(shadow_region_enable),
        .single_region_select(single_region_select), .wide_cpu(wide_cpu),
        .wait_wr(wait_wr), .wait_val(wait_val), .shadow_wait_setting(shadow_wait_setting),
        .wait_illegal(wait_illegal), .clk_is_8mhz(clk_is_8mhz),
        .clk_above_8mhz(clk_above_8mhz), .as_b(as_b), .rw(rw), .fc(fc), .addr(addr),
        .shadow_ready_signal(shadow_ready_signal), .ovl_sel(ovl_sel), .ovl_we(ovl_we),
        .ovl_addr(ovl_addr), .dsack_b(dsack_b), .port16(port16), .tgt_wait(tgt_wait),
        .write_viol(write_viol), .access_viol(access_viol));
    omd_cpu_model i_cpu (.mclk(mclk), .dsack_b(dsack_b), .ovl_sel(ovl_sel),
        .ovl_we(ovl_we), .ovl_addr(ovl_addr), .write_viol(write_viol),
        .access_viol(access_viol), .as_b(as_b), .rw(rw), .fc(fc), .addr(addr),
        .shadow_ready_signal(shadow_ready_signal));
    // Free-running 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Target wait monitor, cleared by the bench
    always @(posedge mclk) tw_seen <= (tw_seen && !tw_clr) || tgt_wait;
    // Map write or clear; refusal pulse is read while it stands
    task automatic map_op(input logic c, input logic [31:0] a, input logic [1:0] t);
        @(negedge mclk);
        clear_map_command = c;
        map_wr = !c;
        map_addr = a;
        map_attr = t;
        @(negedge mclk);
        e = c ? clear_refused : map_seg_err;
        clear_map_command = 1'b0;
        map_wr = 1'b0;
    endtask
    // Load a wait setting; the illegal pulse is read while it stands
    task automatic set_wait(input logic [2:0] v);
        @(negedge mclk);
        wait_wr = 1'b1;
        wait_val = v;
        @(negedge mclk);
        e = wait_illegal;
        wait_wr = 1'b0;
    endtask
    task automatic hold_reset();
        rst_b = 1'b0;
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog, well past the expected run of about 700 cycles
    initial begin
        #(6000 * 100);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        {map_wr, clear_map_command, wait_wr, clk_is_8mhz, clk_above_8mhz, tw_clr} = 6'h0;
        {map_addr, map_attr, wait_val, single_region_select} = 40'h0;
        emu_paused = 1'b1;
        wide_cpu = 1'b1;
        shadow_region_enable = omd_pkg::OMD_EN_CODE;
        hold_reset();
        map_op(1'b0, 32'h1f000000, 2'h1);
        `CHK(e, 1'b0)
        map_op(1'b0, 32'h1f100000, 2'h3);
        `CHK(e, 1'b0)
        // Table of ordinary cycles
        for (int i = 0; i < 13; i++) begin
            @(negedge mclk);
            shadow_region_enable = rows[i].md;
            single_region_select = rows[i].one;
            i_cpu.run(rows[i].w, rows[i].f, rows[i].a, flg, oa, n1);
            `CHK(flg, rows[i].x)
            if (rows[i].x[4]) `CHK(oa, rows[i].a[23:0])
            $display("row %0d done", i);
        end
        shadow_region_enable = omd_pkg::OMD_EN_CODE;
        map_op(1'b0, 32'h20000000, 2'h1);
        `CHK(e, 1'b1)
        map_op(1'b0, 32'h20000800, 2'h0);
        `CHK(e, 1'b0)
        emu_paused = 1'b0;
        map_op(1'b1, 32'h0, 2'h0);
        `CHK(e, 1'b1)
        i_cpu.run(1'b0, 3'h6, 32'h1f000010, flg, oa, n1);
        `CHK(flg, 5'h14)
        emu_paused = 1'b1;
        map_op(1'b1, 32'h0, 2'h0);
        `CHK(e, 1'b0)
        i_cpu.run(1'b0, 3'h6, 32'h1f000010, flg, oa, n1);
        `CHK(flg, 5'h00)
        map_op(1'b0, 32'h20000000, 2'h1);
        `CHK(e, 1'b0)
        i_cpu.run(1'b0, 3'h6, 32'h20000010, flg, oa, n1);
        `CHK(oa, 24'h000010)
        $display("window test done");
        map_op(1'b0, 32'h20000800, 2'h2);
        map_op(1'b0, 32'h20001000, 2'h3);
        i_cpu.run(1'b1, 3'h6, 32'h20000800, flg, oa, n1);
        `CHK(flg[3:1], 3'h3)
        i_cpu.run(1'b0, 3'h6, 32'h20001000, flg, oa, n1);
        `CHK(flg[2:0], 3'h1)
        $display("violation test done");
        // Target access inside and outside the overlay window, fast clock
        @(negedge mclk);
        clk_above_8mhz = 1'b1;
        tw_clr = 1'b1;
        @(negedge mclk);
        tw_clr = 1'b0;
        i_cpu.run(1'b0, 3'h6, 32'h20004000, flg, oa, n1);
        `CHK({tw_seen, flg[2]}, 2'h2)
        @(negedge mclk);
        tw_clr = 1'b1;
        @(negedge mclk);
        tw_clr = 1'b0;
        i_cpu.run(1'b0, 3'h6, 32'h30004000, flg, oa, n1);
        `CHK(tw_seen, 1'b0)
        clk_above_8mhz = 1'b0;
        $display("target wait test done");
        set_wait(3'h0);
        `CHK({e, shadow_wait_setting}, 4'h9)
        set_wait(3'h7);
        `CHK({e, shadow_wait_setting}, 4'h7)
        i_cpu.run(1'b0, 3'h6, 32'h20000010, flg, oa, n1);
        clk_is_8mhz = 1'b1;
        i_cpu.run(1'b0, 3'h6, 32'h20000010, flg, oa, n2);
        `CHK({flg[2], n2 < n1}, 2'h3)
        clk_is_8mhz = 1'b0;
        $display("wait test done");
        hold_reset();
        `CHK({shadow_wait_setting, dsack_b}, 4'h3)
        i_cpu.run(1'b0, 3'h6, 32'h20000010, flg, oa, n1);
        `CHK(flg, 5'h00)
        $display("reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
